/* pkg/flag_pkg.sv */
// constants for the system flag manager
package flag_pkg;
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_SITE     = 8'h08;
  localparam logic [7:0] ADDR_LATCH    = 8'h0c;
  localparam logic [7:0] ADDR_TIME     = 8'h10;
  localparam logic [7:0] ADDR_CARD     = 8'h14;
  localparam int NUM_FLAGS    = 8;
  localparam int F_LAMP       = 0;
  localparam int F_ENCL       = 1;
  localparam int F_INTR       = 2;
  localparam int F_DURESS     = 3;
  localparam int F_POWER      = 4;
  localparam int F_ARRIVE     = 5;
  localparam int F_DEPART     = 6;
  localparam int F_BADGE      = 7;
  localparam int SITE_LSB     = 16;
  localparam int SITE_W       = 8;
  localparam int CARD_W       = 40;
  localparam int SECOND_NS    = 1000000000;
  localparam int CLK_NS       = 100;
  localparam int TICK_CYCLES  = SECOND_NS / CLK_NS;
  localparam logic [15:0] TIME_RESET = 16'h0005;
endpackage

/* hdl/system_flag_manager.sv */
// system flag manager with apb register access
// What this block does
// - set coerced-entry flag on duress PIN
// - power fault on mains, battery, link loss
// - arrival grace on delayed intrusion input
// - timers and disarming clear listed flags
// - badge hold set on card removal
// - site code from card bits 16..23
// - reduced code leading byte is site
// - site-matched cards get site user group
// - all flags inactive after reset
// - latched timers hold flag until event
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module system_flag_manager
  import flag_pkg::*;
#(
  parameter int TICK = TICK_CYCLES
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  input  wire logic              duressPin,
  input  wire logic              inMainsLost,
  input  wire logic              inLowBattery,
  input  wire logic              extLinkLost,
  input  wire logic              inDelayedIntrusion,
  input  wire logic              inTamper,
  input  wire logic              inIntrusion,
  input  wire logic              inLampSet,
  input  wire logic              inLampClear,
  input  wire logic              inLampToggle,
  input  wire logic              badgeRemoved,
  input  wire logic              armEvent,
  input  wire logic              disarmEvent,
  input  wire logic              cardValid,
  input  wire logic [CARD_W-1:0] cardCode,
  output logic [NUM_FLAGS-1:0]   flags,
  output logic                   siteGrant,
  output logic [3:0]             siteUserGroup
);
  // pins from outside: three stages, level settles once stages 2 and 3 agree
  localparam int NPIN = 11;
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] s1;
  logic [NPIN-1:0] s2;
  logic [NPIN-1:0] s3;
  logic [NPIN-1:0] pinLvl;
  logic [NPIN-1:0] rise;
  assign pinRaw = {duressPin, inMainsLost, inLowBattery, extLinkLost, inDelayedIntrusion,
                   inTamper, inIntrusion, inLampSet, inLampClear, inLampToggle, badgeRemoved};
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      pinLvl <= '0;
    end else begin
      s1 <= pinRaw;
      s2 <= s1;
      s3 <= s2;
      pinLvl <= (s2 & s3) | (pinLvl & (s2 | s3));
    end
  end
  assign rise = s2 & s3 & ~pinLvl;
  logic evDuress;
  logic evMains;
  logic evBatt;
  logic evLink;
  logic evDelay;
  logic evTamper;
  logic evIntr;
  logic evLSet;
  logic evLClr;
  logic evLTog;
  logic evBadge;
  assign {evDuress, evMains, evBatt, evLink, evDelay, evTamper, evIntr, evLSet, evLClr, evLTog, evBadge} = rise;

  // registers
  logic                 enable;
  logic                 siteEnable;
  logic [SITE_W-1:0]    siteCode;
  logic [3:0]           siteGroup;
  logic [NUM_FLAGS-1:0] latchMode;
  logic [15:0]          flagTime;
  logic [SITE_W-1:0]    lastSite;
  logic                 next_enable;
  logic                 next_siteEnable;
  logic [SITE_W-1:0]    next_siteCode;
  logic [3:0]           next_siteGroup;
  logic [NUM_FLAGS-1:0] next_latchMode;
  logic [15:0]          next_flagTime;
  logic                 wrEn;
  logic                 access;
  logic [31:0]          next_prdata;
  assign access = psel & penable;
  assign wrEn = access & pwrite;
  assign pready = 1'b1;
  always_comb begin
    next_enable = enable;
    next_siteEnable = siteEnable;
    next_siteCode = siteCode;
    next_siteGroup = siteGroup;
    next_latchMode = latchMode;
    next_flagTime = flagTime;
    if (wrEn) begin
      unique case (paddr)
        ADDR_CTRL: begin
          next_enable = pwdata[0];
          next_siteEnable = pwdata[1];
          next_siteGroup = pwdata[7:4];
        end
        ADDR_SITE: next_siteCode = pwdata[SITE_W-1:0];
        ADDR_LATCH: next_latchMode = pwdata[NUM_FLAGS-1:0];
        ADDR_TIME: next_flagTime = pwdata[15:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      enable <= 1'b1;
      siteEnable <= 1'b0;
      siteCode <= '0;
      siteGroup <= '0;
      latchMode <= '0;
      flagTime <= TIME_RESET;
      prdata <= '0;
    end else begin
      enable <= next_enable;
      siteEnable <= next_siteEnable;
      siteCode <= next_siteCode;
      siteGroup <= next_siteGroup;
      latchMode <= next_latchMode;
      flagTime <= next_flagTime;
      prdata <= next_prdata;
    end
  end
  always_comb begin
    next_prdata = prdata;
    pslverr = 1'b0;
    // read data is registered in the setup cycle and stands through the access cycle
    if (psel && !pwrite) begin
      unique case (paddr)
        ADDR_CTRL: next_prdata = {24'h000000, siteGroup, 2'b00, siteEnable, enable};
        ADDR_STATUS: next_prdata = {24'h000000, flags};
        ADDR_SITE: next_prdata = {24'h000000, siteCode};
        ADDR_LATCH: next_prdata = {24'h000000, latchMode};
        ADDR_TIME: next_prdata = {16'h0000, flagTime};
        ADDR_CARD: next_prdata = {24'h000000, lastSite};
        default: pslverr = penable;
      endcase
    end else if (access) begin
      unique case (paddr)
        ADDR_CTRL, ADDR_SITE, ADDR_LATCH, ADDR_TIME: pslverr = 1'b0;
        default: pslverr = 1'b1;
      endcase
    end
  end

  // one-second tick
  logic [31:0] tickCnt;
  logic [31:0] next_tickCnt;
  logic        tick;
  assign tick = (tickCnt == 32'(TICK - 1));
  always_comb begin
    next_tickCnt = tick ? '0 : tickCnt + 32'h00000001;
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tickCnt <= '0;
    end else begin
      tickCnt <= next_tickCnt;
    end
  end

  // flags and their timers
  logic [NUM_FLAGS-1:0] setEv;
  logic [NUM_FLAGS-1:0] clrEv;
  logic [NUM_FLAGS-1:0] next_flags;
  logic [15:0]          timer     [NUM_FLAGS];
  logic [15:0]          next_timer[NUM_FLAGS];
  logic [NUM_FLAGS-1:0] expire;
  always_comb begin
    setEv = '0;
    clrEv = '0;
    setEv[F_DURESS] = evDuress;
    setEv[F_POWER] = evMains | evBatt | evLink;
    setEv[F_ARRIVE] = evDelay;
    setEv[F_BADGE] = evBadge;
    setEv[F_DEPART] = armEvent;
    setEv[F_ENCL] = evTamper;
    setEv[F_INTR] = evTamper | evIntr;
    setEv[F_LAMP] = evLSet;
    clrEv[F_ENCL] = disarmEvent;
    clrEv[F_INTR] = disarmEvent;
    clrEv[F_POWER] = disarmEvent;
    clrEv[F_ARRIVE] = disarmEvent;
    clrEv[F_DEPART] = disarmEvent;
    clrEv[F_LAMP] = evLClr;
  end
  always_comb begin
    for (int i = 0; i < NUM_FLAGS; i++) begin
      expire[i] = flags[i] && !latchMode[i] && tick && (timer[i] == 16'h0001);
      next_flags[i] = flags[i];
      next_timer[i] = timer[i];
      if (flags[i] && tick && timer[i] != 16'h0000) begin
        next_timer[i] = timer[i] - 16'h0001;
      end
      if (expire[i] || clrEv[i]) begin
        next_flags[i] = 1'b0;
      end
      if (i == F_LAMP && evLTog) begin
        next_flags[i] = ~flags[i];
        next_timer[i] = flagTime;
      end
      // set wins over clear
      if (setEv[i] && enable) begin
        next_flags[i] = 1'b1;
        next_timer[i] = flagTime;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags <= '0;
      for (int i = 0; i < NUM_FLAGS; i++) begin
        timer[i] <= '0;
      end
    end else begin
      flags <= next_flags;
      for (int i = 0; i < NUM_FLAGS; i++) begin
        timer[i] <= next_timer[i];
      end
    end
  end

  // site code match
  logic [SITE_W-1:0] cardSite;
  logic              next_siteGrant;
  logic [3:0]        next_siteUserGroup;
  logic [SITE_W-1:0] next_lastSite;
  assign cardSite = cardCode[SITE_LSB +: SITE_W];
  always_comb begin
    next_lastSite = cardValid ? cardSite : lastSite;
    next_siteGrant = cardValid && siteEnable && (cardSite == siteCode);
    next_siteUserGroup = next_siteGrant ? siteGroup : 4'h0;
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      siteGrant <= 1'b0;
      siteUserGroup <= '0;
      lastSite <= '0;
    end else begin
      siteGrant <= next_siteGrant;
      siteUserGroup <= next_siteUserGroup;
      lastSite <= next_lastSite;
    end
  end

  chk_duress_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    evDuress && enable |=> flags[F_DURESS]) else $error("duress flag not set");
  chk_duress_disarm: assert property (@(posedge clk_sys) disable iff (sys_rst)
    flags[F_DURESS] && disarmEvent && !expire[F_DURESS] |=> flags[F_DURESS]) else $error("duress cleared by disarm");
  chk_power_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (evMains || evBatt || evLink) && enable |=> flags[F_POWER]) else $error("power fault not set");
  chk_arrive_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    disarmEvent && !evDelay |=> !flags[F_ARRIVE]) else $error("arrival not cleared");
  chk_timer_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    expire[F_INTR] && !setEv[F_INTR] |=> !flags[F_INTR]) else $error("timer did not clear");
  chk_badge_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    evBadge && enable |=> flags[F_BADGE] && timer[F_BADGE] == $past(flagTime)) else $error("badge hold");
  chk_site_grant: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cardValid && siteEnable && cardCode[23:16] == siteCode |=> siteGrant && siteUserGroup == $past(siteGroup))
    else $error("site grant missing");
  chk_latch_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    flags[F_POWER] && latchMode[F_POWER] && !disarmEvent |=> flags[F_POWER]) else $error("latched flag dropped");
  chk_lamp_toggle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    evLTog && !evLSet |=> flags[F_LAMP] == !$past(flags[F_LAMP])) else $error("lamp toggle wrong");
  cov_duress: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(flags[F_DURESS]));
  cov_expire: cover property (@(posedge clk_sys) disable iff (sys_rst) expire[F_BADGE]);
  cov_grant: cover property (@(posedge clk_sys) disable iff (sys_rst) siteGrant);
endmodule
`default_nettype wire

/* bench/flag_partner.sv */
// far-side model: input lines, card reader and arming logic
`timescale 1ns/1ns
`default_nettype none
module flag_partner
  import flag_pkg::*;
(
  input  wire logic        clk_sys,
  output logic [10:0]      pins,
  output logic             armEvent,
  output logic             disarmEvent,
  output logic             cardValid,
  output logic [CARD_W-1:0] cardCode
);
  initial begin
    pins = 11'h000;
    armEvent = 1'h0;
    disarmEvent = 1'h0;
    cardValid = 1'h0;
    cardCode = '0;
  end
  // levels held long enough for the input synchronisers
  task automatic pulse(input logic [10:0] mask);
    @(posedge clk_sys);
    pins <= mask;
    repeat (4) @(posedge clk_sys);
    pins <= 11'h000;
    // low long enough for the input filter to see the release
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic arm(input logic dis);
    @(posedge clk_sys);
    armEvent <= ~dis;
    disarmEvent <= dis;
    @(posedge clk_sys);
    armEvent <= 1'h0;
    disarmEvent <= 1'h0;
  endtask
  task automatic card(input logic [CARD_W-1:0] code);
    @(posedge clk_sys);
    cardValid <= 1'h1;
    cardCode <= code;
    @(posedge clk_sys);
    cardValid <= 1'h0;
    // code is stale once valid falls
    cardCode <= ~code;
  endtask
endmodule
`default_nettype wire

/* bench/system_flag_manager_tb.sv */
// self-checking bench for the system flag manager
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, exp, got) begin testsRun++; if ((got) !== (exp)) begin badCount++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module system_flag_manager_tb
  import flag_pkg::*;
;
  logic                 clk_sys = 1'h0;
  logic                 sys_rst;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [7:0]           paddr;
  logic [31:0]          pwdata;
  logic                 pready, pslverr, armEvent, disarmEvent, cardValid, siteGrant, rerr;
  logic [31:0]          prdata, rdata;
  logic [10:0]          pins;
  logic [CARD_W-1:0]    cardCode;
  logic [NUM_FLAGS-1:0] flags;
  logic [3:0]           siteUserGroup;
  int                   badCount = 0;
  int                   testsRun = 0;
  // sources: duress, mains, battery, link, delayed, tamper, intrusion, lamp set, badge
  logic [10:0]          srcMask [9] = '{11'h001, 11'h002, 11'h004, 11'h008, 11'h010, 11'h020, 11'h040,
                                        11'h080, 11'h400};
  logic [7:0]           setMask [9] = '{8'h08, 8'h10, 8'h10, 8'h10, 8'h20, 8'h06, 8'h04, 8'h01, 8'h80};
  always #50 clk_sys = ~clk_sys;
  flag_partner far (.clk_sys(clk_sys), .pins(pins), .armEvent(armEvent), .disarmEvent(disarmEvent),
    .cardValid(cardValid), .cardCode(cardCode));
  system_flag_manager #(.TICK(10)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .duressPin(pins[0]), .inMainsLost(pins[1]),
    .inLowBattery(pins[2]), .extLinkLost(pins[3]), .inDelayedIntrusion(pins[4]), .inTamper(pins[5]),
    .inIntrusion(pins[6]), .inLampSet(pins[7]), .inLampClear(pins[8]), .inLampToggle(pins[9]),
    .badgeRemoved(pins[10]), .armEvent(armEvent), .disarmEvent(disarmEvent), .cardValid(cardValid),
    .cardCode(cardCode), .flags(flags), .siteGrant(siteGrant), .siteUserGroup(siteUserGroup));
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n = 0;
    @(posedge clk_sys);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clk_sys);
    penable <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n == 50) badCount++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic expectFlags(input logic [7:0] exp);
    apb(1'h0, ADDR_STATUS, 32'h0);
    `CHECK("status", {24'h0, exp}, rdata)
    `CHECK("flags", exp, flags)
  endtask
  task automatic conclude();
    $display("Checks run %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    badCount++;
    conclude();
  end
  initial begin
    sys_rst <= 1'h1;
    psel <= 1'h0;
    penable <= 1'h0;
    pwrite <= 1'h0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'h0;
    expectFlags(8'h00);
    apb(1'h0, ADDR_TIME, 32'h0);
    `CHECK("time reset", 32'h5, rdata)
    apb(1'h0, ADDR_CTRL, 32'h0);
    `CHECK("ctrl reset", 32'h1, rdata)
    apb(1'h0, 8'h3c, 32'h0);
    `CHECK("unmapped error", 1'h1, rerr)
    apb(1'h1, ADDR_TIME, 32'h3);
    for (int i = 0; i < 9; i++) begin
      far.pulse(srcMask[i]);
      expectFlags(setMask[i]);
      repeat (50) @(posedge clk_sys);
      expectFlags(8'h00);
    end
    far.pulse(11'h0b3);
    far.arm(1'h0);
    expectFlags(8'h7f);
    far.arm(1'h1);
    expectFlags(8'h09);
    repeat (50) @(posedge clk_sys);
    expectFlags(8'h00);
    far.pulse(11'h200);
    expectFlags(8'h01);
    far.pulse(11'h200);
    expectFlags(8'h00);
    far.pulse(11'h200);
    far.pulse(11'h100);
    expectFlags(8'h00);
    apb(1'h1, ADDR_STATUS, 32'h0);
    `CHECK("status write error", 1'h1, rerr)
    apb(1'h1, ADDR_LATCH, 32'h11);
    far.pulse(11'h082);
    repeat (50) @(posedge clk_sys);
    expectFlags(8'h11);
    far.pulse(11'h100);
    expectFlags(8'h10);
    far.arm(1'h1);
    expectFlags(8'h00);
    apb(1'h1, ADDR_LATCH, 32'h0);
    apb(1'h1, ADDR_CTRL, 32'h30);
    far.pulse(11'h020);
    expectFlags(8'h00);
    apb(1'h1, ADDR_SITE, 32'hee);
    apb(1'h1, ADDR_CTRL, 32'h33);
    far.card(40'hff_ffee_ffff);
    #1;
    `CHECK("grant", 1'h1, siteGrant)
    `CHECK("group", 4'h3, siteUserGroup)
    apb(1'h0, ADDR_CARD, 32'h0);
    `CHECK("card site", 32'hee, rdata)
    far.card(40'h00_00ef_ee00);
    #1;
    `CHECK("no grant", 1'h0, siteGrant)
    `CHECK("no group", 4'h0, siteUserGroup)
    apb(1'h1, ADDR_CTRL, 32'h31);
    far.card(40'h00_00ee_0000);
    #1;
    `CHECK("site off", 1'h0, siteGrant)
    far.pulse(11'h020);
    expectFlags(8'h06);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'h0;
    expectFlags(8'h00);
    apb(1'h0, ADDR_CTRL, 32'h0);
    `CHECK("ctrl after reset", 32'h1, rdata)
    conclude();
  end
endmodule
`default_nettype wire
